// file: rvt_pkg.sv
// Constants, types and decoders shared by the ring validation timer
package rvt_pkg;

  // ------------------------------------------------------------
  // Clock and step timing
  // ------------------------------------------------------------
  localparam int unsigned RVT_CLOCK_PERIOD_NS = 100;
  localparam int unsigned RVT_STEP_NS = 2000000;
  localparam int unsigned RVT_STEP_MS = 2;
  localparam int unsigned RVT_TICK_CYCLES = RVT_STEP_NS / RVT_CLOCK_PERIOD_NS;

  // ------------------------------------------------------------
  // Field layout of the ring validation control byte
  // ------------------------------------------------------------
  localparam int unsigned RVT_MAXCNT_LSB = 0;
  localparam int unsigned RVT_MAXCNT_MSB = 3;
  localparam int unsigned RVT_TIMEOUT_LSB = 4;
  localparam int unsigned RVT_TIMEOUT_MSB = 7;
  localparam int unsigned RVT_ASSERT_W = 6;
  localparam int unsigned RVT_FIELD_W = 4;
  localparam int unsigned RVT_END_W = 10;

  // ------------------------------------------------------------
  // Ring end timeout figures
  // ------------------------------------------------------------
  localparam int unsigned RVT_TIMEOUT_CODE0_MS = 80;
  localparam int unsigned RVT_TIMEOUT_UNIT_MS = 128;
  localparam logic [RVT_END_W-1:0] RVT_END_RESET = 10'h000;
  localparam logic [RVT_ASSERT_W-1:0] RVT_TIMER_RESET = 6'h00;

  typedef enum logic [0:0] {
    RVT_IDLE = 1'b0,
    RVT_QUAL = 1'b1
  } rvt_state_t;

  typedef struct packed {
    logic [RVT_ASSERT_W-1:0] assert_time;
    logic [7:0] control;
  } rvt_cfg_t;

  typedef struct packed {
    logic ring_active;
    logic ring_valid;
    logic accepted;
    logic reject_high;
    logic reject_low;
    logic ring_end;
    logic [RVT_ASSERT_W-1:0] timer;
  } rvt_status_t;

  // Code 0 is 80 ms, every other code n is n x 128 ms; result in 2 ms steps
  function automatic logic [RVT_END_W-1:0] rvt_timeout_steps(input logic [RVT_FIELD_W-1:0] code);
    int unsigned ms;
    ms = (code == 4'h0) ? RVT_TIMEOUT_CODE0_MS : RVT_TIMEOUT_UNIT_MS * int'(code);
    return RVT_END_W'(ms / RVT_STEP_MS);
  endfunction

endpackage

// file: rvt_tick.sv
// Step generator: one pulse per 2 ms step, realigned on each ring event
`timescale 1ns/1ps
module rvt_tick #(
  parameter int unsigned TICK_CYCLES = rvt_pkg::RVT_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic restart,
  output logic tick
);

  localparam int unsigned CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_r;

  generate
    if (TICK_CYCLES < 2)
    begin : g_bad
      $error("rvt_tick: TICK_CYCLES must be at least 2");
    end
  endgenerate

  // Restart keeps the first step after an event a whole step long
  always_ff @(posedge clock)
  begin
    if (srst || restart)
      cnt_r <= '0;
    else if (cnt_r == LAST)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CW'(1);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      tick <= 1'b0;
    else
      tick <= !restart && (cnt_r == LAST);
  end

endmodule // rvt_tick

// file: rvt_ring_timer.sv
// Ring validation timer: qualifies ring crossing events by their spacing
// Functional notes
// - Bits 3:0 hold the maximum count
// - Each crossing reloads timer, then counts down
// - Timer above maximum count rejects ring
// - Assertion time and maximum count fields count 2 ms steps
// - Crossing after timer expiry rejects ring
// - Bits 7:4 set ring end timeout
`timescale 1ns/1ps
module rvt_ring_timer #(
  parameter int unsigned TICK_CYCLES = rvt_pkg::RVT_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ring_crossing,
  input wire rvt_pkg::rvt_cfg_t cfg,
  output rvt_pkg::rvt_status_t status
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  rvt_pkg::rvt_state_t state_r;
  logic sync_a_r;
  logic sync_b_r;
  logic sync_c_r;
  logic evt;
  logic tick;
  logic [rvt_pkg::RVT_ASSERT_W-1:0] timer_r;
  logic [rvt_pkg::RVT_END_W-1:0] end_cnt_r;
  logic [rvt_pkg::RVT_FIELD_W-1:0] max_count;
  logic [rvt_pkg::RVT_FIELD_W-1:0] end_code;
  logic too_high;
  logic too_low;
  logic end_hit;
  logic valid_r;
  logic accepted_r;
  logic reject_high_r;
  logic reject_low_r;
  logic ring_end_r;

  generate
    if (TICK_CYCLES < 2)
    begin : g_bad
      $error("rvt_ring_timer: TICK_CYCLES must be at least 2");
    end
  endgenerate

  // ------------------------------------------------------------
  // Crossing input synchroniser and edge
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
      sync_c_r <= 1'b0;
    end
    else
    begin
      sync_a_r <= ring_crossing;
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
    end
  end

  assign evt = sync_b_r && !sync_c_r;

  rvt_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .srst(srst),
    .restart(evt),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  // Maximum count field
  assign max_count = cfg.control[rvt_pkg::RVT_MAXCNT_MSB:rvt_pkg::RVT_MAXCNT_LSB];
  assign end_code = cfg.control[rvt_pkg::RVT_TIMEOUT_MSB:rvt_pkg::RVT_TIMEOUT_LSB];

  // Remaining time above maximum count means crossings too close
  assign too_high = (timer_r != '0) && (timer_r > {2'h0, max_count});
  // Timer already run out means crossings too far apart
  assign too_low = (timer_r == '0);
  assign end_hit = (state_r == rvt_pkg::RVT_QUAL) && tick && !evt
                   && (end_cnt_r == rvt_pkg::RVT_END_W'(1));

  // ------------------------------------------------------------
  // Qualification state
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      state_r <= rvt_pkg::RVT_IDLE;
    else
      unique case (state_r)
        rvt_pkg::RVT_IDLE:
          if (evt)
            state_r <= rvt_pkg::RVT_QUAL;
        rvt_pkg::RVT_QUAL:
          if (end_hit)
            state_r <= rvt_pkg::RVT_IDLE;
      endcase
  end

  // ------------------------------------------------------------
  // Ring timer
  // ------------------------------------------------------------
  // Reload on crossing, count down per step
  always_ff @(posedge clock)
  begin
    if (srst)
      timer_r <= rvt_pkg::RVT_TIMER_RESET;
    else if (evt)
      timer_r <= cfg.assert_time;
    else if (tick && state_r == rvt_pkg::RVT_QUAL && timer_r != '0)
      timer_r <= timer_r - rvt_pkg::RVT_ASSERT_W'(1);
  end

  // ------------------------------------------------------------
  // Ring end timer
  // ------------------------------------------------------------
  // Timeout restarts from latest crossing
  always_ff @(posedge clock)
  begin
    if (srst)
      end_cnt_r <= rvt_pkg::RVT_END_RESET;
    else if (evt)
      end_cnt_r <= rvt_pkg::rvt_timeout_steps(end_code);
    else if (tick && state_r == rvt_pkg::RVT_QUAL && end_cnt_r != '0)
      end_cnt_r <= end_cnt_r - rvt_pkg::RVT_END_W'(1);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ring_end_r <= 1'b0;
    else
      ring_end_r <= end_hit;
  end

  // ------------------------------------------------------------
  // Verdicts
  // ------------------------------------------------------------
  // Judge each later crossing against remaining time
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      accepted_r <= 1'b0;
      reject_high_r <= 1'b0;
      reject_low_r <= 1'b0;
    end
    else
    begin
      accepted_r <= evt && state_r == rvt_pkg::RVT_QUAL && !too_high && !too_low;
      reject_high_r <= evt && state_r == rvt_pkg::RVT_QUAL && too_high;
      reject_low_r <= evt && state_r == rvt_pkg::RVT_QUAL && too_low;
    end
  end

  // A rejected crossing still starts a fresh interval, so a ring can recover
  always_ff @(posedge clock)
  begin
    if (srst)
      valid_r <= 1'b0;
    else if (reject_high_r || reject_low_r || ring_end_r)
      valid_r <= 1'b0;
    else if (accepted_r)
      valid_r <= 1'b1;
  end

  assign status.ring_active = (state_r == rvt_pkg::RVT_QUAL);
  assign status.ring_valid = valid_r;
  assign status.accepted = accepted_r;
  assign status.reject_high = reject_high_r;
  assign status.reject_low = reject_low_r;
  assign status.ring_end = ring_end_r;
  assign status.timer = timer_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_qual_evt;
    state_r == rvt_pkg::RVT_QUAL && evt;
  endsequence

  sequence s_step;
    tick && !evt && state_r == rvt_pkg::RVT_QUAL && timer_r != '0;
  endsequence

  a_timer_reload: assert property (@(posedge clock) disable iff (srst)
    evt |=> timer_r == $past(cfg.assert_time))
    else $error("ring timer not reloaded on crossing");

  a_timer_step: assert property (@(posedge clock) disable iff (srst)
    s_step |=> timer_r == $past(timer_r) - 6'h01)
    else $error("ring timer did not step down");

  a_timer_hold: assert property (@(posedge clock) disable iff (srst)
    !tick && !evt |=> $stable(timer_r))
    else $error("ring timer moved between steps");

  a_tick_spacing: assert property (@(posedge clock) disable iff (srst)
    tick |=> !tick [*1])
    else $error("step ticks back to back");

  a_reject_high: assert property (@(posedge clock) disable iff (srst)
    s_qual_evt ##0 (timer_r > {2'h0, max_count}) |=> reject_high_r && !accepted_r ##1 !valid_r)
    else $error("fast ring not rejected");

  a_accept_window: assert property (@(posedge clock) disable iff (srst)
    s_qual_evt ##0 (timer_r != '0 && timer_r <= {2'h0, max_count}) |=> accepted_r ##1 valid_r)
    else $error("in-band crossing not accepted");

  a_reject_low: assert property (@(posedge clock) disable iff (srst)
    s_qual_evt ##0 (timer_r == '0) |=> reject_low_r && !reject_high_r)
    else $error("slow ring not rejected");

  a_end_load: assert property (@(posedge clock) disable iff (srst)
    evt |=> end_cnt_r == rvt_pkg::rvt_timeout_steps($past(end_code)))
    else $error("ring end timer not loaded from timeout code");

  a_ring_end: assert property (@(posedge clock) disable iff (srst)
    end_hit |=> ring_end_r && state_r == rvt_pkg::RVT_IDLE ##1 !ring_end_r && !valid_r)
    else $error("ring end did not close the ring");

endmodule // rvt_ring_timer

// file: rvt_ring_src.sv
// Line-side model: turns a bench request into one ring crossing pulse on the pin
`timescale 1ns/1ps
module rvt_ring_src #(
  parameter int unsigned HIGH_CYCLES = 4
) (
  input wire logic clock,
  input wire logic fire,
  output logic ring_crossing
);
  int unsigned left_r = 0;

  // Wide enough for the two-flop synchroniser, low between crossings
  always_ff @(posedge clock)
  begin
    if (fire)
    begin
      left_r <= HIGH_CYCLES;
    end
    else if (left_r != 0)
    begin
      left_r <= left_r - 1;
    end
  end

  assign ring_crossing = (left_r != 0);
endmodule // rvt_ring_src

// file: rvt_ring_timer_tb.sv
// Self-checking bench for the ring validation timer
`timescale 1ns/1ps
module rvt_ring_timer_tb;
  localparam int unsigned TICK = 8;
  localparam logic [5:0] ASSERT_STEPS = 6'h0a;
  logic clock;
  logic srst;
  logic fire;
  logic ring_crossing;
  rvt_pkg::rvt_cfg_t cfg;
  rvt_pkg::rvt_status_t status;
  int fails;
  int checks_done;

  rvt_ring_timer #(.TICK_CYCLES(TICK)) uut (
    .clock(clock),
    .srst(srst),
    .ring_crossing(ring_crossing),
    .cfg(cfg),
    .status(status)
  );

  rvt_ring_src src (
    .clock(clock),
    .fire(fire),
    .ring_crossing(ring_crossing)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic final_report();
    if (fails == 0 && checks_done > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic send_crossing();
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask

  // Consumes a fixed 8 cycles so crossing spacing stays exact
  task automatic take_verdict(input logic [2:0] exp);
    logic [2:0] seen;
    seen = 3'h0;
    repeat (8)
    begin
      @(posedge clock);
      #1;
      seen = seen | {status.accepted, status.reject_high, status.reject_low};
    end
    check_val({9'h0, seen}, {9'h0, exp}, "verdict");
    check_val({6'h0, status.timer}, {6'h0, ASSERT_STEPS}, "timer reload");
    check_val({10'h0, status.ring_active, status.ring_valid}, {10'h0, 1'b1, exp[2]}, "valid");
  endtask

  // Half-tick offset keeps the sampled timer clear of a decrement edge
  task automatic cross_after(input int unsigned steps, input logic [2:0] exp);
    repeat (steps * TICK + TICK / 2 - 10) @(posedge clock);
    send_crossing();
    take_verdict(exp);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Timer equal to the maximum passes, one above fails, reload after reject
  task automatic sc_max_boundary();
    send_crossing();
    take_verdict(3'h0);
    cross_after(6, 3'h4);
    cross_after(5, 3'h2);
    cross_after(6, 3'h4);
  endtask

  // Last step before expiry passes, a crossing after expiry fails
  task automatic sc_too_slow();
    cross_after(9, 3'h4);
    cross_after(10, 3'h1);
  endtask

  task automatic sc_ring_end(input logic [3:0] code);
    int unsigned n;
    int unsigned steps;
    steps = (code == 4'h0) ? 40 : 64 * code;
    n = 0;
    while (status.ring_active !== 1'b0 && n < 20000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (status.ring_active !== 1'b0)
    begin
      fails++;
      $display("CHECK FAILED at %0t: ring never went idle", $time);
      final_report();
    end
    @(posedge clock);
    cfg.control <= {code, 4'h4};
    send_crossing();
    n = 2;
    while (status.ring_end !== 1'b1 && n < steps * TICK + 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (status.ring_end !== 1'b1)
    begin
      fails++;
      $display("CHECK FAILED at %0t: no ring end", $time);
      final_report();
    end
    // Sync latency sits inside one step, so an extra or missing step shows
    check_val({11'h0, n >= steps * TICK && n <= steps * TICK + TICK}, 12'h001,
      "ring end time");
    repeat (2) @(posedge clock);
    #1;
    check_val({10'h0, status.ring_active, status.ring_valid}, 12'h000, "after end");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    fails = 0;
    checks_done = 0;
    fire = 1'b0;
    srst = 1'b1;
    // Max count 4 steps suits assertion 10 steps and a 50 Hz lower limit
    cfg = '{assert_time: ASSERT_STEPS, control: 8'h04};
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check_val(status, 12'h000, "status after reset");
    sc_max_boundary();
    sc_too_slow();
    sc_ring_end(4'h0);
    sc_ring_end(4'h1);
    sc_ring_end(4'h2);
    sc_ring_end(4'hf);
    final_report();
  end
endmodule // rvt_ring_timer_tb
